// ---- hdl/status_ctrl_regs.vh ----
// Offsets, fields, codes and reset values for the status and regulator control logic
`ifndef STATUS_CTRL_REGS_VH
`define STATUS_CTRL_REGS_VH

// Subcommand codes
`define CMD_ENTER_CFG_EDIT   16'h0090
`define CMD_EXIT_CFG_EDIT    16'h0092
`define CMD_SCRATCHPAD       16'h0070
`define CMD_LDO_RUNTIME      16'h0098
`define CMD_SLEEP_ENABLE     16'h0099
`define CMD_SLEEP_DISABLE    16'h009a

// Status flag bit positions
`define STAT_CFG_EDIT        0
`define STAT_STATE_A       1
`define STAT_SLEEP_EN        2
`define STAT_FULL_RESET      3
`define STAT_WDOG            4
`define STAT_OTP_PEND        6
`define STAT_SEC_LO          8
`define STAT_SEC_HI          9

// Security state codes
`define SEC_UNINIT           2'h0
`define SEC_FULL_ACCESS      2'h1
`define SEC_UNSEALED         2'h2
`define SEC_SEALED           2'h3

// Regulator config field positions
`define REGCFG_A_EN          0
`define REGCFG_A_VSEL_LO     1
`define REGCFG_A_VSEL_HI     3
`define REGCFG_B_EN          4
`define REGCFG_B_VSEL_LO     5
`define REGCFG_B_VSEL_HI     7

// Reset value and scratchpad size
`define REGCFG_RESET         8'h00
`define SCRATCH_BYTES        32
`define SCRATCH_ADDR_W       5

// Voltage codes in tenths of a volt
`define VOLT_1V8             6'h12
`define VOLT_2V5             6'h19
`define VOLT_3V0             6'h1e
`define VOLT_3V3             6'h21
`define VOLT_5V0             6'h32

`endif

// ---- hdl/permanent_store.v ----
// Permanent (one-time-programmable) scratchpad store with power-up load
`timescale 1ns/100ps
`include "status_ctrl_regs.vh"

module permanent_store (
	// Clock and reset
	input  wire       ref_clk,
	input  wire       rst,
	// Program port, only sets bits
	input  wire       progValid,
	input  wire [4:0] progAddr,
	input  wire [7:0] progData,
	// Read port
	input  wire [4:0] rdAddr,
	output wire [7:0] rdData,
	// Regulator settings
	input  wire       regProg,
	input  wire [7:0] regProgData,
	input  wire       preProg,
	input  wire       preProgData,
	output wire [7:0] regStored,
	output wire       preStored
);

	// ============================================================
	// Storage
	// Cells survive rst: only power-up clears them, like a fuse array.
	reg [7:0] cellMem [0:`SCRATCH_BYTES-1];
	reg [7:0] regCell_reg;
	reg       preCell_reg;
	integer   i;

	initial begin
		for (i = 0; i < `SCRATCH_BYTES; i = i + 1) begin
			cellMem[i] = 8'h00;
		end
		regCell_reg = 8'h00;
		preCell_reg = 1'b0;
	end

	always @(posedge ref_clk) begin
		// Programming can only set bits; none is burnt while reset is held
		if (progValid && !rst) begin
			cellMem[progAddr] <= cellMem[progAddr] | progData;
		end
		if (regProg && !rst) begin
			regCell_reg <= regCell_reg | regProgData;
		end
		if (preProg && !rst) begin
			preCell_reg <= preCell_reg | preProgData;
		end
	end

	assign rdData    = cellMem[rdAddr];
	assign regStored = regCell_reg;
	assign preStored = preCell_reg;

endmodule // permanent_store

// ---- hdl/status_scratchpad_ldo_ctrl.v ----
// Device status flags, manufacturing scratchpad and regulator control
//
// Contract
// - Bit 4 marks watchdog-caused previous reset
// - Bit 3 full reset, cleared at edit exit
// - Bit 2 sleep permission, config default, commands
// - Bit 1 state_a; drives state_a switch instead
// - Bit 0 set after edit-entry command processed
// - Config changes accepted only in edit mode
// - 32-byte scratchpad via scratchpad command
// - Scratchpad writes only in full access
// - Write RAM, then permanent write if enabled
// - Permanent write waits for good voltage, temperature
// - Outside edit mode bits only set
// - In edit mode clear only if permanently zero
// - Pre-regulator on needs its bit and one LDO
// - Voltage select codes map to levels
// - Runtime LDO command applies 8-bit config
// - Regulators off by default, load stored settings
// - Output driver high level source selectable
// - Security field encoding of four states
`timescale 1ns/100ps
`include "status_ctrl_regs.vh"

module status_scratchpad_ldo_ctrl (
	// Clock and reset
	input  wire        ref_clk,
	input  wire        rst,
	// Reset cause, from the reset controller on this clock
	input  wire        wdogResetCause,
	input  wire        fullResetCause,
	// Configuration defaults and state inputs
	input  wire        sleepEnDefault,
	input  wire        permanentWriteEnable,
	input  wire [1:0]  securityState,
	input  wire        stateA,
	input  wire        chargeRequest,
	// Programming conditions, asynchronous monitor comparators
	input  wire        batVoltOk,
	input  wire        tempOk,
	// Subcommand port
	input  wire        cmdValid,
	input  wire [15:0] cmdCode,
	input  wire        cmdWrite,
	input  wire [4:0]  cmdAddr,
	input  wire [7:0]  cmdWrData,
	output reg         cmdDone,
	output reg         cmdRejected,
	output reg  [7:0]  cmdRdData,
	// Configuration write port (edit mode only)
	input  wire        cfgWrValid,
	input  wire        cfgSelPre,
	input  wire [7:0]  cfgWrData,
	// Output driver level select per multifunction pin
	input  wire [5:0]  drvSrcSel,
	output reg  [5:0]  drvFromLdoA,
	// Status
	output wire [15:0] deviceStatusFlags,
	// Regulator and switch controls
	output reg         preRegEnable,
	output reg         ldoAEnable,
	output reg         ldoBEnable,
	output reg  [5:0]  ldoAVolt,
	output reg  [5:0]  ldoBVolt,
	output reg  [7:0]  regulatorConfig,
	output reg         prechargeDrive,
	output reg         chargeDrive
);

	// ============================================================
	// Helpers
	function [5:0] voltOf;
		input [2:0] code;
		begin
			case (code)
				3'h4:    voltOf = `VOLT_2V5;
				3'h5:    voltOf = `VOLT_3V0;
				3'h6:    voltOf = `VOLT_3V3;
				3'h7:    voltOf = `VOLT_5V0;
				default: voltOf = `VOLT_1V8;
			endcase
		end
	endfunction

	// ============================================================
	// Synchronise analog comparator levels
	reg [1:0] voltSync_reg;
	reg [1:0] tempSync_reg;
	wire      progOk = voltSync_reg[1] & tempSync_reg[1];

	always @(posedge ref_clk) begin
		if (rst) begin
			voltSync_reg <= 2'h0;
			tempSync_reg <= 2'h0;
		end else begin
			voltSync_reg <= {voltSync_reg[0], batVoltOk};
			tempSync_reg <= {tempSync_reg[0], tempOk};
		end
	end

	// ============================================================
	// State
	localparam ST_LOAD = 2'h0;
	localparam ST_RUN  = 2'h1;
	localparam ST_PROG = 2'h2;

	reg  [1:0] state_reg;
	reg  [1:0] state_next;
	reg  [4:0] progIdx_reg;
	reg  [`SCRATCH_BYTES-1:0] dirty_reg;
	reg  [7:0] scratchMem [0:`SCRATCH_BYTES-1];
	reg        cfgEdit_reg;
	reg        fullReset_reg;
	reg        wdog_reg;
	reg        sleepEn_reg;
	reg        preCfg_reg;
	reg        regDirty_reg;
	reg        pending_reg;
	wire [7:0] storedByte;
	wire [7:0] regStored;
	wire       preStored;
	wire       progValid;
	wire       regProg;

	wire isScratch = cmdValid && cmdCode == `CMD_SCRATCHPAD;
	wire isEnter   = cmdValid && cmdCode == `CMD_ENTER_CFG_EDIT;
	wire isExit    = cmdValid && cmdCode == `CMD_EXIT_CFG_EDIT;
	wire isLdo     = cmdValid && cmdCode == `CMD_LDO_RUNTIME;
	wire scratchWrOk = isScratch && cmdWrite && securityState == `SEC_FULL_ACCESS;
	wire [7:0] curByte = scratchMem[cmdAddr];
	reg  [7:0] newByte;

	always @* begin
		newByte = curByte | cmdWrData;
		if (cfgEdit_reg) begin
			// clear only bits still zero permanently
			newByte = cmdWrData | storedByte;
		end
	end

	permanent_store store (
		.ref_clk     (ref_clk),
		.rst         (rst),
		.progValid   (progValid),
		.progAddr    (progIdx_reg),
		.progData    (scratchMem[progIdx_reg]),
		.rdAddr      (state_reg == ST_LOAD ? progIdx_reg : cmdAddr),
		.rdData      (storedByte),
		.regProg     (regProg),
		.regProgData (regulatorConfig),
		.preProg     (regProg),
		.preProgData (preCfg_reg),
		.regStored   (regStored),
		.preStored   (preStored)
	);

	assign progValid = state_reg == ST_PROG && progOk && dirty_reg[progIdx_reg];
	assign regProg   = state_reg == ST_PROG && progOk && progIdx_reg == 5'h1f && regDirty_reg;

	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_LOAD: if (progIdx_reg == 5'h1f) state_next = ST_RUN;
			ST_RUN:  if (pending_reg && !cfgEdit_reg) state_next = ST_PROG;
			ST_PROG: if (progOk && progIdx_reg == 5'h1f) state_next = ST_RUN;
			default: state_next = ST_LOAD;
		endcase
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			state_reg       <= ST_LOAD;
			progIdx_reg     <= 5'h00;
			dirty_reg       <= {`SCRATCH_BYTES{1'b0}};
			cfgEdit_reg     <= 1'b0;
			fullReset_reg   <= 1'b0;
			wdog_reg        <= 1'b0;
			sleepEn_reg     <= 1'b0;
			preCfg_reg      <= 1'b0;
			regDirty_reg    <= 1'b0;
			pending_reg     <= 1'b0;
			regulatorConfig <= `REGCFG_RESET;
			cmdDone         <= 1'b0;
			cmdRejected     <= 1'b0;
			cmdRdData       <= 8'h00;
		end else begin
			state_reg   <= state_next;
			cmdDone     <= 1'b0;
			cmdRejected <= 1'b0;
			case (state_reg)
				ST_LOAD: begin
					scratchMem[progIdx_reg] <= storedByte;
					progIdx_reg             <= progIdx_reg + 5'h01;
					if (progIdx_reg == 5'h00) begin
						regulatorConfig <= regStored;
						preCfg_reg      <= preStored;
						wdog_reg        <= wdogResetCause;
						fullReset_reg   <= fullResetCause;
						sleepEn_reg     <= sleepEnDefault;
					end
				end
				ST_PROG: begin
					if (progOk) begin
						dirty_reg[progIdx_reg] <= 1'b0;
						progIdx_reg            <= progIdx_reg + 5'h01;
						if (progIdx_reg == 5'h1f) begin
							pending_reg  <= 1'b0;
							regDirty_reg <= 1'b0;
						end
					end
				end
				default: begin
					progIdx_reg <= 5'h00;
				end
			endcase
			if (state_reg == ST_RUN) begin
				if (isEnter) begin
					cfgEdit_reg <= 1'b1;
					cmdDone     <= 1'b1;
				end else if (isExit) begin
					cfgEdit_reg   <= 1'b0;
					fullReset_reg <= 1'b0;
					if (permanentWriteEnable && (|dirty_reg || regDirty_reg)) begin
						pending_reg <= 1'b1;
					end
					cmdDone <= 1'b1;
				end else if (cmdValid && cmdCode == `CMD_SLEEP_ENABLE) begin
					sleepEn_reg <= 1'b1;
					cmdDone     <= 1'b1;
				end else if (cmdValid && cmdCode == `CMD_SLEEP_DISABLE) begin
					sleepEn_reg <= 1'b0;
					cmdDone     <= 1'b1;
				end else if (isScratch && !cmdWrite) begin
					cmdRdData <= curByte;
					cmdDone   <= 1'b1;
				end else if (scratchWrOk) begin
					scratchMem[cmdAddr] <= newByte;
					dirty_reg[cmdAddr]  <= permanentWriteEnable;
					if (permanentWriteEnable && !cfgEdit_reg) begin
						pending_reg <= 1'b1;
					end
					cmdDone <= 1'b1;
				end else if (isLdo) begin
					regulatorConfig <= cmdWrData;
					cmdDone         <= 1'b1;
				end else if (cfgWrValid && cfgEdit_reg) begin
					// config writes in edit mode only
					if (cfgSelPre) begin
						preCfg_reg <= cfgWrData[0];
					end else begin
						regulatorConfig <= cfgWrData;
					end
					regDirty_reg <= 1'b1;
					cmdDone      <= 1'b1;
				end else if (cmdValid || cfgWrValid) begin
					cmdRejected <= 1'b1;
				end
			end else if (cmdValid || cfgWrValid) begin
				cmdRejected <= 1'b1;
			end
		end
	end

	// ============================================================
	// Outputs
	// Level inputs are flopped so that every flag bit leaves from a register
	reg        stateSeen_reg;
	reg  [1:0] securitySeen_reg;

	assign deviceStatusFlags = {6'h00, securitySeen_reg, 1'b0, pending_reg, 1'b0,
		wdog_reg, fullReset_reg, sleepEn_reg, stateSeen_reg, cfgEdit_reg};

	always @(posedge ref_clk) begin
		if (rst) begin
			preRegEnable   <= 1'b0;
			ldoAEnable     <= 1'b0;
			ldoBEnable     <= 1'b0;
			ldoAVolt       <= `VOLT_1V8;
			ldoBVolt       <= `VOLT_1V8;
			prechargeDrive <= 1'b0;
			chargeDrive    <= 1'b0;
			drvFromLdoA    <= 6'h00;
			stateSeen_reg    <= 1'b0;
			securitySeen_reg <= `SEC_UNINIT;
		end else begin
			// state_a flag follows the state input
			stateSeen_reg    <= stateA;
			securitySeen_reg <= securityState;
			preRegEnable <= preCfg_reg & (regulatorConfig[`REGCFG_A_EN] |
				regulatorConfig[`REGCFG_B_EN]);
			ldoAEnable   <= regulatorConfig[`REGCFG_A_EN];
			ldoBEnable   <= regulatorConfig[`REGCFG_B_EN];
			ldoAVolt     <= voltOf(regulatorConfig[`REGCFG_A_VSEL_HI:`REGCFG_A_VSEL_LO]);
			ldoBVolt     <= voltOf(regulatorConfig[`REGCFG_B_VSEL_HI:`REGCFG_B_VSEL_LO]);
			prechargeDrive <= chargeRequest & stateA;
			chargeDrive    <= chargeRequest & ~stateA;
			drvFromLdoA    <= drvSrcSel;
		end
	end

endmodule // status_scratchpad_ldo_ctrl

// ---- test/status_ctrl_checker.sv ----
// Assertion checker for the status and regulator control block
`timescale 1ns/100ps
module status_ctrl_checker (
	// Clock and reset
	input wire		ref_clk,
	input wire		rst,
	// Commands
	input wire		cmdValid,
	input wire		cmdWrite,
	input wire [15:0]	cmdCode,
	input wire		cfgWrValid,
	input wire [1:0]	securityState,
	input wire		cmdRejected,
	// Status and regulators
	input wire [15:0]	deviceStatusFlags,
	input wire [7:0]	regulatorConfig,
	input wire		preRegEnable,
	input wire		ldoAEnable,
	input wire [5:0]	ldoAVolt,
	input wire		prechargeDrive,
	input wire		chargeDrive
);
	function [5:0] volt(input [2:0] c);
		volt = c == 3'h7 ? 6'h32 : c == 3'h6 ? 6'h21 : c == 3'h5 ? 6'h1e : c == 3'h4 ? 6'h19 : 6'h12;
	endfunction
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// ========
	// Properties
	a_edit_after_cmd: assert property ($rose(deviceStatusFlags[0])
		|-> $past(cmdValid && cmdCode == 16'h0090)) else $error("edit flag rose alone");
	a_fullreset_clear: assert property ($fell(deviceStatusFlags[3])
		|-> $past(cmdValid && cmdCode == 16'h0092)) else $error("reset flag cleared early");
	a_scratch_guard: assert property (cmdValid && cmdCode == 16'h0070 && cmdWrite
		&& securityState != 2'h1 |=> cmdRejected) else $error("scratch write not refused");
	a_cfg_guard: assert property (cfgWrValid && !cmdValid && !deviceStatusFlags[0]
		|=> cmdRejected) else $error("config write not refused");
	a_switch_excl: assert property (!(prechargeDrive && chargeDrive))
		else $error("both switch drivers on");
	a_prereg_gate: assert property (preRegEnable
		|-> $past(regulatorConfig[0] | regulatorConfig[4])) else $error("pre-regulator alone");
	a_ldo_follow: assert property (ldoAEnable == $past(regulatorConfig[0]))
		else $error("ldo a enable stale");
	a_volt_map: assert property (ldoAVolt == volt($past(regulatorConfig[3:1])))
		else $error("ldo a voltage wrong");
endmodule // status_ctrl_checker

bind status_scratchpad_ldo_ctrl status_ctrl_checker chk (.ref_clk(ref_clk), .rst(rst),
	.cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cfgWrValid(cfgWrValid),
	.securityState(securityState), .cmdRejected(cmdRejected),
	.deviceStatusFlags(deviceStatusFlags), .regulatorConfig(regulatorConfig),
	.preRegEnable(preRegEnable), .ldoAEnable(ldoAEnable), .ldoAVolt(ldoAVolt),
	.prechargeDrive(prechargeDrive), .chargeDrive(chargeDrive));

// ---- test/host_model.sv ----
// Host model issuing subcommands to the status and regulator control block
`timescale 1ns/100ps
module host_model (
	// Clock
	input wire		ref_clk,
	// Subcommand port
	output reg		cmdValid,
	output reg [15:0]	cmdCode,
	output reg		cmdWrite,
	output reg [4:0]	cmdAddr,
	output reg [7:0]	cmdWrData,
	input wire		cmdDone,
	input wire		cmdRejected,
	input wire [7:0]	cmdRdData
);
	initial begin
		cmdValid = 0;
		cmdCode = 16'h0000;
		cmdWrite = 0;
		cmdAddr = 5'h00;
		cmdWrData = 8'h00;
	end
	// one byte a command: drive it for one cycle, then sample the answer
	task xfer(input [15:0] c, input w, input [4:0] a, input [7:0] d, output rej,
		output [7:0] rd);
		@(posedge ref_clk);
		#1;
		cmdValid = 1;
		cmdCode = c;
		cmdWrite = w;
		cmdAddr = a;
		cmdWrData = d;
		@(posedge ref_clk);
		#1;
		// Released fields show garbage so a stale value is never mistaken for data
		cmdValid = 0;
		cmdCode = ~c;
		cmdWrite = ~w;
		cmdAddr = ~a;
		cmdWrData = ~d;
		rej = cmdRejected | ~cmdDone;
		rd = cmdRdData;
	endtask
endmodule // host_model

// ---- test/status_scratchpad_ldo_ctrl_bench.sv ----
// Self-checking bench for the status and regulator control block
`timescale 1ns/100ps
module status_scratchpad_ldo_ctrl_bench;
	reg		ref_clk = 0, rst = 1, wdogResetCause = 1, fullResetCause = 1;
	reg		sleepEnDefault = 1, permanentWriteEnable = 0, stateA = 0, chargeRequest = 0;
	reg		batVoltOk = 0, tempOk = 0, cfgWrValid = 0, cfgSelPre = 0, rej;
	reg [1:0]	securityState = 2'h3;
	reg [7:0]	cfgWrData = 8'h00, rd;
	reg [5:0]	drvSrcSel = 6'h00;
	wire		cmdValid, cmdWrite, cmdDone, cmdRejected, preRegEnable, ldoAEnable;
	wire		ldoBEnable, prechargeDrive, chargeDrive;
	wire [15:0]	cmdCode, deviceStatusFlags;
	wire [4:0]	cmdAddr;
	wire [7:0]	cmdWrData, cmdRdData, regulatorConfig;
	wire [5:0]	drvFromLdoA, ldoAVolt, ldoBVolt;
	integer		errors = 0, n_compared = 0, i;

	status_scratchpad_ldo_ctrl dut (.ref_clk(ref_clk), .rst(rst),
		.wdogResetCause(wdogResetCause), .fullResetCause(fullResetCause),
		.sleepEnDefault(sleepEnDefault), .permanentWriteEnable(permanentWriteEnable),
		.securityState(securityState), .stateA(stateA), .chargeRequest(chargeRequest),
		.batVoltOk(batVoltOk), .tempOk(tempOk), .cmdValid(cmdValid), .cmdCode(cmdCode),
		.cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdWrData(cmdWrData), .cmdDone(cmdDone),
		.cmdRejected(cmdRejected), .cmdRdData(cmdRdData), .cfgWrValid(cfgWrValid),
		.cfgSelPre(cfgSelPre), .cfgWrData(cfgWrData), .drvSrcSel(drvSrcSel),
		.drvFromLdoA(drvFromLdoA), .deviceStatusFlags(deviceStatusFlags),
		.preRegEnable(preRegEnable), .ldoAEnable(ldoAEnable), .ldoBEnable(ldoBEnable),
		.ldoAVolt(ldoAVolt), .ldoBVolt(ldoBVolt), .regulatorConfig(regulatorConfig),
		.prechargeDrive(prechargeDrive), .chargeDrive(chargeDrive));
	host_model host (.ref_clk(ref_clk), .cmdValid(cmdValid), .cmdCode(cmdCode),
		.cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdWrData(cmdWrData), .cmdDone(cmdDone),
		.cmdRejected(cmdRejected), .cmdRdData(cmdRdData));

	initial forever #2.5 ref_clk = ~ref_clk;
	// ========
	// Helpers
	task chk(input string name, input [15:0] seen, input [15:0] exp);
		n_compared = n_compared + 1;
		if (seen !== exp) begin
			errors = errors + 1;
			$display("unexpected %0s: expected %h seen %h", name, exp, seen);
		end
	endtask
	task stop_test;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task cyc(input integer n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// Load phase rejects everything, so wait it out before the first command
	task do_reset(input wd);
		wdogResetCause = wd;
		rst = 1;
		cyc(4);
		rst = 0;
		cyc(33);
	endtask
	task cfgw(input pre, input [7:0] d, input expRej);
		@(posedge ref_clk);
		#1;
		cfgWrValid = 1;
		cfgSelPre = pre;
		cfgWrData = d;
		cyc(1);
		cfgWrValid = 0;
		cfgWrData = ~d;
		chk("cfg answer", {cmdRejected, cmdDone}, {expRej, !expRej});
	endtask
	task scr(input w, input [4:0] a, input [7:0] d);
		host.xfer(16'h0070, w, a, d, rej, rd);
	endtask
	function [5:0] vexp(input integer c);
		vexp = c == 7 ? 6'h32 : c == 6 ? 6'h21 : c == 5 ? 6'h1e : c == 4 ? 6'h19 : 6'h12;
	endfunction
	// ========
	// Scenarios
	task t_after_reset;
		chk("flags", deviceStatusFlags & 16'h031f, 16'h031c);
		chk("regs off", {preRegEnable, ldoAEnable, ldoBEnable}, 3'h0);
	endtask
	task t_sleep_switch;
		host.xfer(16'h009a, 0, 5'h00, 8'h00, rej, rd);
		chk("sleep off", deviceStatusFlags[2], 1'b0);
		host.xfer(16'h0099, 0, 5'h00, 8'h00, rej, rd);
		chk("sleep on", deviceStatusFlags[2], 1'b1);
		stateA = 1;
		chargeRequest = 1;
		drvSrcSel = 6'h2a;
		cyc(3);
		chk("pchg", {deviceStatusFlags[1], prechargeDrive, chargeDrive}, 3'h6);
		chk("drv src", drvFromLdoA, 6'h2a);
		stateA = 0;
		cyc(3);
		chk("chg", {deviceStatusFlags[1], prechargeDrive, chargeDrive}, 3'h1);
	endtask
	task t_access;
		cfgw(0, 8'h01, 1);
		for (i = 0; i < 4; i = i + 1) begin
			securityState = i[1:0];
			scr(1, i[4:0], 8'h80);
			chk("sec write", rej, i != 1);
			scr(0, i[4:0], 8'h00);
			chk("sec read", {rej, rd}, i == 1 ? 9'h080 : 9'h000);
		end
		securityState = 2'h1;
	endtask
	task t_bits;
		scr(1, 5'h1f, 8'h0f);
		scr(1, 5'h1f, 8'hf0);
		scr(1, 5'h1f, 8'h00);
		scr(0, 5'h1f, 8'h00);
		chk("set only", rd, 8'hff);
		host.xfer(16'h0090, 0, 5'h00, 8'h00, rej, rd);
		chk("edit", deviceStatusFlags[0], 1'b1);
		scr(1, 5'h1f, 8'h00);
		scr(0, 5'h1f, 8'h00);
		chk("edit clear", rd, 8'h00);
		cfgw(1, 8'h01, 0);
		cfgw(0, 8'h09, 0);
		cyc(2);
		chk("ldo a", {preRegEnable, ldoAEnable, ldoAVolt}, 8'hd9);
		host.xfer(16'h0092, 0, 5'h00, 8'h00, rej, rd);
		chk("exit", {deviceStatusFlags[3], deviceStatusFlags[0]}, 2'h0);
	endtask
	task t_volt;
		for (i = 0; i < 9; i = i + 1) begin
			host.xfer(16'h0098, 1, 5'h00, i == 8 ? 8'h00 : {i[2:0], 1'b0, i[2:0], 1'b1}, rej, rd);
			cyc(1);
			chk("ldo a", {ldoAEnable, ldoAVolt}, {i < 8, vexp(i & 7)});
			chk("ldo b", {ldoBEnable, ldoBVolt}, {1'b0, vexp(i & 7)});
			chk("pre", preRegEnable, i < 8);
		end
	endtask
	task t_permanent;
		permanentWriteEnable = 1;
		scr(1, 5'h00, 8'h01);
		cyc(40);
		chk("pending", deviceStatusFlags[6], 1'b1);
		batVoltOk = 1;
		tempOk = 1;
		i = 0;
		while (deviceStatusFlags[6] !== 1'b0 && i < 300) begin
			cyc(1);
			i = i + 1;
		end
		chk("programmed", i < 300, 1'b1);
		if (i == 300)
			stop_test;
		fullResetCause = 0;
		sleepEnDefault = 0;
		do_reset(0);
		chk("reset cause", deviceStatusFlags[4:2], 3'h0);
		host.xfer(16'h0090, 0, 5'h00, 8'h00, rej, rd);
		scr(1, 5'h00, 8'h00);
		scr(0, 5'h00, 8'h00);
		chk("stored kept", rd, 8'h01);
	endtask
	initial begin
		do_reset(1);
		t_after_reset;
		t_sleep_switch;
		t_access;
		t_bits;
		t_volt;
		t_permanent;
		stop_test;
	end
endmodule // status_scratchpad_ldo_ctrl_bench
